// *** src/agu_cfg.svh ***
// Purpose: constants for the address arithmetic unit and loop register set
// Assumes: 32-bit addresses, byte addressing, one core clock
// Notes: modifier control uses one 4-bit field per low pointer
`ifndef AGU_CFG_SVH
`define AGU_CFG_SVH
`define AGU_AW          32
`define AGU_NPTR        8
`define AGU_NSHARED     4
`define AGU_NLOOP       4
`define AGU_NFLAG       5
`define AGU_MODIFIER_CONTROL_REGISTER_FLD    4
`define AGU_MODIFIER_CONTROL_REGISTER_EN_BIT 3
`define AGU_ADDR_RST    32'h0000_0000
`define AGU_MODIFIER_CONTROL_REGISTER_RST    32'h0000_0000
`endif

// *** src/agu_core.sv ***
// Purpose: address pointers, shared modifiers, base registers and loop registers
// Assumes: one access per cycle; software follows loop nesting order
// Notes: register writes and the access update to the same pointer: access wins
`timescale 1ns/1ps
`include "agu_cfg.svh"
module agu_core
  import agu_pkg::*;
(
  // clock and reset
  input  wire logic                   clk_sys,
  input  wire logic                   sys_rst,
  // register write port: sel 0..7 pointers, 8..15 base (extra pointers)
  input  wire logic                   ptr_wr,
  input  wire logic [3:0]             ptr_wr_sel,
  input  wire logic [`AGU_AW-1:0]     ptr_wr_data,
  input  wire logic                   ofs_wr,
  input  wire logic [1:0]             ofs_wr_sel,
  input  wire logic [`AGU_AW-1:0]     ofs_wr_data,
  input  wire logic                   mod_wr,
  input  wire logic [1:0]             mod_wr_sel,
  input  wire logic [`AGU_AW-1:0]     mod_wr_data,
  input  wire logic                   modifier_control_register_wr,
  input  wire logic [`AGU_AW-1:0]     modifier_control_register_wr_data,
  // access request
  input  wire logic                   acc_valid,
  input  wire agu_pkg::agu_mode_t     acc_mode,
  input  wire agu_pkg::agu_width_t    acc_width,
  input  wire logic [3:0]             acc_ptr,
  input  wire logic [1:0]             acc_ofs_sel,
  input  wire logic [3:0]             acc_idx_ptr,
  // access result
  output logic      [`AGU_AW-1:0]     acc_addr,
  output logic                        acc_addr_valid,
  // loop control
  input  wire agu_pkg::agu_loop_op_t  loop_op,
  input  wire logic [1:0]             loop_sel,
  input  wire logic [`AGU_AW-1:0]     loop_data,
  // status and readback
  output logic [`AGU_NFLAG-1:0]       loop_flags,
  output logic [`AGU_AW-1:0]          modifier_control_register_out,
  output logic [`AGU_AW-1:0]          ptr_rd_data,
  input  wire logic [3:0]             ptr_rd_sel,
  output logic [`AGU_AW-1:0]          loop_start_rd,
  output logic [`AGU_AW-1:0]          loop_count_rd
);
  // sixteen pointer storage: 0..7 pointers, 8..15 base registers
  agu_addr_t address_pointer_q [2*`AGU_NPTR];
  agu_addr_t offset_register_q [`AGU_NSHARED];
  agu_addr_t modulus_register_q [`AGU_NSHARED];
  agu_addr_t modifier_control_register_q;
  agu_addr_t loop_start_address_q [`AGU_NLOOP];
  agu_addr_t loop_iteration_count_q [`AGU_NLOOP];
  logic [`AGU_NFLAG-1:0] loop_flag_q;
  agu_addr_t acc_addr_q;
  logic      acc_addr_valid_q;

  agu_addr_t cur;
  agu_addr_t ofs_sel;
  agu_addr_t delta;
  agu_addr_t nxt;
  agu_addr_t base_sel;
  agu_addr_t mod_sel;
  logic      mod_en;
  logic      upd;
  logic [`AGU_MODIFIER_CONTROL_REGISTER_FLD-1:0] mfld;

  // modulo field of a low pointer from the modifier control register
  function automatic logic [`AGU_MODIFIER_CONTROL_REGISTER_FLD-1:0] modifier_control_register_field(input agu_addr_t m,
                                                          input logic [2:0] p);
    modifier_control_register_field = m[p*`AGU_MODIFIER_CONTROL_REGISTER_FLD +: `AGU_MODIFIER_CONTROL_REGISTER_FLD];
  endfunction

  // sign-preserving shift to the access width
  function automatic agu_addr_t scale(input agu_addr_t v, input agu_width_t w);
    scale = v << w;
  endfunction

  // operand selection; any offset register pairs with any pointer
  always_comb begin
    cur      = address_pointer_q[acc_ptr];
    ofs_sel  = offset_register_q[acc_ofs_sel];
    base_sel = address_pointer_q[{1'b1, acc_ptr[2:0]}];
    // field decoded once; a select straight on a call result is not legal
    mfld     = modifier_control_register_field(modifier_control_register_q, acc_ptr[2:0]);
    mod_sel  = modulus_register_q[mfld[1:0]];
    // only low pointers can be in modulo mode
    mod_en   = !acc_ptr[3] && mfld[`AGU_MODIFIER_CONTROL_REGISTER_EN_BIT];
    delta    = '0;
    upd      = 1'b0;
    unique case (acc_mode)
      AGU_NOP: begin
        upd = 1'b0;
      end
      AGU_POST_INC: begin
        delta = scale(`AGU_AW'(1), acc_width);
        upd   = 1'b1;
      end
      AGU_POST_DEC: begin
        delta = -scale(`AGU_AW'(1), acc_width);
        upd   = 1'b1;
      end
      AGU_POST_OFS: begin
        delta = scale(ofs_sel, acc_width);
        upd   = 1'b1;
      end
      AGU_IDX_N0: begin
        delta = scale(offset_register_q[0], acc_width);
      end
      AGU_IDX_PTR: begin
        delta = scale(address_pointer_q[acc_idx_ptr], acc_width);
      end
      default: begin
        upd = 1'b0; // unused codes; there is no pre-decrement mode
      end
    endcase
  end

  agu_modulo u_modulo (
    .cur     (cur),
    .delta   (delta),
    .base    (base_sel),
    .modulus (mod_sel),
    .mod_en  (mod_en),
    .nxt     (nxt)
  );

  // access address: post modes use the old pointer, indexed modes the sum
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      acc_addr_q       <= `AGU_ADDR_RST;
      acc_addr_valid_q <= 1'b0;
    end else begin
      acc_addr_valid_q <= acc_valid && acc_mode != AGU_NOP;
      // a no-op leaves the last address standing
      if (acc_valid && acc_mode != AGU_NOP) begin
        acc_addr_q <= (acc_mode == AGU_IDX_N0 || acc_mode == AGU_IDX_PTR) ? nxt : cur;
      end
    end
  end

  // pointer bank; a base register of a non-modulo pointer is an extra pointer
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      for (int i = 0; i < 2*`AGU_NPTR; i++) begin
        address_pointer_q[i] <= `AGU_ADDR_RST;
      end
    end else begin
      if (ptr_wr) begin
        address_pointer_q[ptr_wr_sel] <= ptr_wr_data;
      end
      if (acc_valid && upd) begin
        address_pointer_q[acc_ptr] <= nxt;
      end
    end
  end

  // shared offset and modulus registers
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      for (int i = 0; i < `AGU_NSHARED; i++) begin
        offset_register_q[i]  <= `AGU_ADDR_RST;
        modulus_register_q[i] <= `AGU_ADDR_RST;
      end
    end else begin
      if (ofs_wr) begin
        offset_register_q[ofs_wr_sel] <= ofs_wr_data;
      end
      if (mod_wr) begin
        modulus_register_q[mod_wr_sel] <= mod_wr_data;
      end
    end
  end

  // modifier control
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      modifier_control_register_q <= `AGU_MODIFIER_CONTROL_REGISTER_RST;
    end else if (modifier_control_register_wr) begin
      modifier_control_register_q <= modifier_control_register_wr_data;
    end
  end

  // loop registers: one dedicated pair per nesting level
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      for (int i = 0; i < `AGU_NLOOP; i++) begin
        loop_start_address_q[i]   <= `AGU_ADDR_RST;
        loop_iteration_count_q[i] <= `AGU_ADDR_RST;
      end
    end else begin
      unique case (loop_op)
        AGU_LOOP_NONE: begin
        end
        AGU_LOOP_SETUP: begin
          loop_start_address_q[loop_sel] <= loop_data;
        end
        AGU_LOOP_EN: begin
          loop_iteration_count_q[loop_sel] <= loop_data;
        end
        AGU_LOOP_DONE: begin
        end
      endcase
    end
  end

  // next value of the four per-level flags, used for the summary flag
  function automatic logic [`AGU_NLOOP-1:0] loop_flag_d_low(
      input logic [`AGU_NFLAG-1:0] f, input agu_loop_op_t op, input logic [1:0] s);
    loop_flag_d_low = f[`AGU_NLOOP-1:0];
    if (op == AGU_LOOP_EN) begin
      loop_flag_d_low[s] = 1'b1;
    end else if (op == AGU_LOOP_DONE) begin
      loop_flag_d_low[s] = 1'b0;
    end
  endfunction

  // loop flags: bits 0..3 loop active, bit 4 any loop active
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      loop_flag_q <= '0;
    end else begin
      if (loop_op == AGU_LOOP_EN) begin
        loop_flag_q[loop_sel] <= 1'b1;
      end else if (loop_op == AGU_LOOP_DONE) begin
        loop_flag_q[loop_sel] <= 1'b0;
      end
      loop_flag_q[`AGU_NFLAG-1] <= |loop_flag_d_low(loop_flag_q, loop_op, loop_sel);
    end
  end

  assign acc_addr       = acc_addr_q;
  assign acc_addr_valid = acc_addr_valid_q;
  assign loop_flags     = loop_flag_q;
  assign modifier_control_register_out       = modifier_control_register_q;
  assign ptr_rd_data    = address_pointer_q[ptr_rd_sel];
  assign loop_start_rd  = loop_start_address_q[loop_sel];
  assign loop_count_rd  = loop_iteration_count_q[loop_sel];
endmodule

// *** src/agu_modulo.sv ***
// Purpose: wraps a pointer update into a modulo buffer of arbitrary base
// Assumes: pointer and delta magnitude stay within one buffer length
// Notes: purely combinational
`timescale 1ns/1ps
`include "agu_cfg.svh"
module agu_modulo (
  // operands
  input  wire logic [`AGU_AW-1:0] cur,
  input  wire logic [`AGU_AW-1:0] delta,
  input  wire logic [`AGU_AW-1:0] base,
  input  wire logic [`AGU_AW-1:0] modulus,
  input  wire logic               mod_en,
  // result
  output logic      [`AGU_AW-1:0] nxt
);
  logic [`AGU_AW-1:0] raw;
  logic [`AGU_AW-1:0] top;
  logic [`AGU_AW-1:0] len;
  logic               neg;
  // bounds from the explicit base, so no alignment is needed
  always_comb begin
    raw = cur + delta;
    top = base + modulus;
    len = modulus + `AGU_AW'(1);
    neg = delta[`AGU_AW-1];
    nxt = raw;
    if (mod_en) begin
      if (neg && (raw < base || raw > cur)) begin
        nxt = raw + len;
      end else if (!neg && (raw > top || raw < cur)) begin
        nxt = raw - len;
      end
    end
  end
endmodule

// *** src/agu_pkg.sv ***
// Purpose: types for the address arithmetic unit
// Assumes: constants come from agu_cfg.svh
// Notes: no pre-decrement code exists in the mode type
`include "agu_cfg.svh"
package agu_pkg;
  typedef logic [`AGU_AW-1:0] agu_addr_t;
  // access width: byte, half, word, double word (shift 0..3)
  typedef enum logic [1:0] {AGU_W8, AGU_W16, AGU_W32, AGU_W64} agu_width_t;
  // addressing modes; pre-decrement by one deliberately absent
  typedef enum logic [2:0] {
    AGU_NOP, AGU_POST_INC, AGU_POST_DEC, AGU_POST_OFS, AGU_IDX_N0, AGU_IDX_PTR
  } agu_mode_t;
  // loop register operations
  typedef enum logic [1:0] {AGU_LOOP_NONE, AGU_LOOP_SETUP, AGU_LOOP_EN, AGU_LOOP_DONE}
    agu_loop_op_t;
endpackage

// *** verification/agu_core_sva.sv ***
// Purpose: port-level checks for the address arithmetic unit and loop registers
// Assumes: one clock domain, synchronous active-high reset
// Notes: the post-modify address check needs ptr_rd_sel aimed at the accessed pointer
`timescale 1ns/1ps
module agu_core_sva
  import agu_pkg::*;
(
  // clock and reset
  input wire logic                  clk_sys,
  input wire logic                  sys_rst,
  // access side
  input wire logic                  acc_valid,
  input wire agu_pkg::agu_mode_t    acc_mode,
  input wire logic [3:0]            acc_ptr,
  input wire logic [3:0]            ptr_rd_sel,
  input wire logic [31:0]           ptr_rd_data,
  input wire logic [31:0]           acc_addr,
  input wire logic                  acc_addr_valid,
  // loop and control side
  input wire agu_pkg::agu_loop_op_t loop_op,
  input wire logic [1:0]            loop_sel,
  input wire logic [31:0]           loop_data,
  input wire logic [4:0]            loop_flags,
  input wire logic [31:0]           loop_count_rd,
  input wire logic                  modifier_control_register_wr,
  input wire logic [31:0]           modifier_control_register_wr_data,
  input wire logic [31:0]           modifier_control_register_out
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  // a real request is any valid cycle that is not a no-op
  wire req = acc_valid && (acc_mode != AGU_NOP);
  wire post = acc_mode inside {AGU_POST_INC, AGU_POST_DEC, AGU_POST_OFS};

  a_valid_follows_req: assert property (req |=> acc_addr_valid)
    else $error("address valid missing after request");
  a_no_spurious_valid: assert property (!req |=> !acc_addr_valid)
    else $error("address valid without request");
  a_addr_holds_idle: assert property (!req |=> $stable(acc_addr))
    else $error("address moved without request");
  a_post_old_ptr: assert property (req && post && acc_ptr == ptr_rd_sel
    |=> acc_addr == $past(ptr_rd_data))
    else $error("post-modify address is not the old pointer");
  a_any_flag_sum: assert property (loop_flags[4] == |loop_flags[3:0])
    else $error("summary loop flag wrong");
  a_loop_en_flag: assert property (loop_op == AGU_LOOP_EN
    |=> loop_flags[$past(loop_sel)] && loop_flags[4])
    else $error("loop flag not raised by enable");
  a_loop_done_clr: assert property (loop_op == AGU_LOOP_DONE
    |=> !loop_flags[$past(loop_sel)])
    else $error("loop flag not cleared");
  a_count_written: assert property (loop_op == AGU_LOOP_EN ##1 loop_sel == $past(loop_sel)
    |-> loop_count_rd == $past(loop_data))
    else $error("loop count not written");
  a_modifier_control_register_follows: assert property (modifier_control_register_wr |=> modifier_control_register_out == $past(modifier_control_register_wr_data))
    else $error("modifier control not written");

  c_idx_ptr: cover property (req && acc_mode == AGU_IDX_PTR);
  c_all_loops: cover property (loop_flags == 5'h1f);
  c_modulo_ofs: cover property (req && acc_mode == AGU_POST_OFS && modifier_control_register_out != 32'h0);
endmodule

bind agu_core agu_core_sva agu_core_sva_inst (.clk_sys, .sys_rst, .acc_valid, .acc_mode,
  .acc_ptr, .ptr_rd_sel, .ptr_rd_data, .acc_addr, .acc_addr_valid, .loop_op, .loop_sel,
  .loop_data, .loop_flags, .loop_count_rd, .modifier_control_register_wr, .modifier_control_register_wr_data, .modifier_control_register_out);

// *** verification/agu_tb.sv ***
// Purpose: directed bench for the address arithmetic unit and loop registers
// Assumes: inputs change on the falling edge, results read half a cycle later
// Notes: write data and selects are shared by all register write strobes
`timescale 1ns/1ps
module testbench;
  import agu_pkg::*;
  logic clk_sys = 0;
  logic sys_rst = 1;
  logic ptr_wr = 0, ofs_wr = 0, mod_wr = 0, modifier_control_register_wr = 0, acc_valid = 0;
  logic [3:0] ptr_wr_sel = 0, acc_ptr = 0, acc_idx_ptr = 0, ptr_rd_sel = 0;
  logic [31:0] ptr_wr_data = 0, loop_data = 0;
  logic [1:0] acc_ofs_sel = 0, loop_sel = 0;
  agu_mode_t acc_mode = AGU_NOP;
  agu_width_t acc_width = AGU_W8;
  agu_loop_op_t loop_op = AGU_LOOP_NONE;
  wire [1:0] ofs_wr_sel = ptr_wr_sel[1:0];
  wire [1:0] mod_wr_sel = ptr_wr_sel[1:0];
  wire [31:0] ofs_wr_data = ptr_wr_data;
  wire [31:0] mod_wr_data = ptr_wr_data;
  wire [31:0] modifier_control_register_wr_data = ptr_wr_data;
  logic [31:0] acc_addr, modifier_control_register_out, ptr_rd_data, loop_start_rd, loop_count_rd;
  logic acc_addr_valid;
  logic [4:0] loop_flags;
  int n_fail = 0;
  int check_count = 0;

  agu_core agu_core_inst (.*);

  // 200 MHz core clock
  always #2.5 clk_sys = ~clk_sys;

  task automatic results();
    if (n_fail == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR %0t: got %h expected %h", $time, g, e);
    end
  endtask

  // k picks the strobe: 0 pointer, 1 offset, 2 modulus, 3 modifier control
  task automatic wr(input int k, input logic [3:0] s, input logic [31:0] d);
    @(negedge clk_sys);
    {ptr_wr, ofs_wr, mod_wr, modifier_control_register_wr} = 4'h8 >> k;
    ptr_wr_sel = s;
    ptr_wr_data = d;
    @(negedge clk_sys);
    {ptr_wr, ofs_wr, mod_wr, modifier_control_register_wr} = 4'h0;
  endtask

  // o doubles as index pointer for the pointer-indexed mode
  task automatic acc(input agu_mode_t m, input agu_width_t w, input logic [3:0] p,
                     input logic [1:0] o, input logic [31:0] ea);
    @(negedge clk_sys);
    acc_valid = 1'b1;
    acc_mode = m;
    acc_width = w;
    acc_ptr = p;
    acc_ofs_sel = o;
    acc_idx_ptr = {2'h0, o};
    ptr_rd_sel = p;
    @(negedge clk_sys);
    acc_valid = 1'b0;
    chk(acc_addr, ea);
    chk({31'h0, acc_addr_valid}, 32'h1);
  endtask

  task automatic rd(input logic [3:0] s, input logic [31:0] e);
    @(negedge clk_sys);
    ptr_rd_sel = s;
    #1 chk(ptr_rd_data, e);
  endtask

  task automatic lop(input agu_loop_op_t op, input logic [1:0] s, input logic [31:0] d);
    @(negedge clk_sys);
    loop_op = op;
    loop_sel = s;
    loop_data = d;
    @(negedge clk_sys);
    loop_op = AGU_LOOP_NONE;
  endtask

  task automatic t_reset();
    rd(4'h0, 32'h0);
    chk(modifier_control_register_out, 32'h0);
    chk({27'h0, loop_flags}, 32'h0);
  endtask

  // second reset in mid-run clears modifier control and pointers
  task automatic t_rerun();
    @(negedge clk_sys);
    sys_rst = 1'b1;
    repeat (2) @(negedge clk_sys);
    sys_rst = 1'b0;
    rd(4'h1, 32'h0);
    chk(modifier_control_register_out, 32'h0);
  endtask

  task automatic t_post();
    wr(0, 4'h1, 32'h100);
    wr(1, 4'h2, 32'hfffffffd);
    acc(AGU_POST_OFS, AGU_W32, 4'h1, 2'h2, 32'h100);
    rd(4'h1, 32'hf4);
    wr(0, 4'h5, 32'h200);
    wr(1, 4'h3, 32'h4);
    acc(AGU_POST_OFS, AGU_W64, 4'h5, 2'h3, 32'h200);
    rd(4'h5, 32'h220);
    acc(AGU_POST_INC, AGU_W8, 4'h5, 2'h0, 32'h220);
    acc(AGU_POST_DEC, AGU_W16, 4'h5, 2'h0, 32'h221);
    rd(4'h5, 32'h21f);
  endtask

  task automatic t_idx();
    wr(0, 4'h2, 32'h40);
    wr(1, 4'h0, 32'h2);
    acc(AGU_IDX_N0, AGU_W16, 4'h2, 2'h2, 32'h44);
    wr(0, 4'h3, 32'h10);
    acc(AGU_IDX_PTR, AGU_W8, 4'h2, 2'h3, 32'h50);
    rd(4'h2, 32'h40);
  endtask

  // unaligned bases, one modulus shared by two buffers, wrap at both ends
  task automatic t_mod();
    wr(2, 4'h0, 32'h7);
    wr(0, 4'h9, 32'h1003);
    wr(0, 4'h1, 32'h1009);
    wr(0, 4'hb, 32'h2001);
    wr(0, 4'h3, 32'h2001);
    wr(1, 4'h1, 32'h1);
    wr(1, 4'h0, 32'hffffffff);
    wr(3, 4'h0, 32'h8080);
    chk(modifier_control_register_out, 32'h8080);
    acc(AGU_POST_OFS, AGU_W32, 4'h1, 2'h1, 32'h1009);
    rd(4'h1, 32'h1005);
    acc(AGU_POST_OFS, AGU_W16, 4'h3, 2'h0, 32'h2001);
    rd(4'h3, 32'h2007);
    wr(0, 4'hc, 32'h300);
    acc(AGU_POST_OFS, AGU_W8, 4'hc, 2'h1, 32'h300);
    rd(4'hc, 32'h301);
  endtask

  task automatic t_loop();
    for (int i = 0; i < 4; i++) begin
      lop(AGU_LOOP_SETUP, 2'(i), 32'h1000 + 32'(i));
      lop(AGU_LOOP_EN, 2'(i), 32'd10 + 32'(i));
      chk(loop_start_rd, 32'h1000 + 32'(i));
      chk(loop_count_rd, 32'd10 + 32'(i));
      chk({27'h0, loop_flags}, 32'h10 | ((32'h1 << (i + 1)) - 32'h1));
    end
    for (int i = 3; i >= 0; i--) lop(AGU_LOOP_DONE, 2'(i), 32'h0);
    chk({27'h0, loop_flags}, 32'h0);
  endtask

  // watchdog: the sequence needs well under a thousand cycles
  initial begin
    #20000;
    n_fail++;
    results();
  end

  initial begin
    repeat (16) @(negedge clk_sys);
    sys_rst = 1'b0;
    t_reset();
    t_post();
    t_idx();
    t_mod();
    t_rerun();
    t_loop();
    results();
  end
endmodule
